// ---- design/int_arith_regs.vh ----
// Register map, field layout, codes and reset values of the extended add / multiply-low slice.
// Assumes an AXI4-Lite master on the same clock and word-aligned 32-bit accesses.
`ifndef INT_ARITH_REGS_VH
`define INT_ARITH_REGS_VH

// Word indices of the registers (byte address = index * 4)
`define IDX_OPERAND_A        4'h0
`define IDX_OPERAND_B        4'h1
`define IDX_IMMEDIATE        4'h2
`define IDX_COMMAND          4'h3
`define IDX_RESULT           4'h4
`define IDX_PRODUCT_HIGH     4'h5
`define IDX_FIXED_POINT_EXC  4'h6
`define IDX_CONDITION_ZERO   4'h7
`define IDX_IRQ_STATUS       4'h8
`define IDX_IRQ_MASK         4'h9

// Address slicing
`define ADDR_WIDTH           8
`define ADDR_IDX_MSB         5
`define ADDR_IDX_LSB         2
`define ADDR_TOP_MSB         7
`define ADDR_TOP_LSB         6

// Command register fields
`define CMD_OP_MSB           2
`define CMD_OP_LSB           0
`define CMD_RECORD_BIT       3
`define CMD_OVF_EN_BIT       4
`define CMD_USED_MASK        32'h0000_001F

// Operation codes
`define OP_ADD_ZERO_EXT      3'h0
`define OP_SUB_ZERO_EXT      3'h1
`define OP_NEGATE            3'h2
`define OP_MUL_LOW_IMM       3'h3
`define OP_MUL_LOW_REG       3'h4

// Fixed-point exception register fields
`define XER_CARRY_BIT        0
`define XER_OVERFLOW_BIT     1
`define XER_SUMMARY_OVF_BIT  2
`define XER_USED_MASK        32'h0000_0007

// Condition field zero: {less, greater, equal, summary overflow}
`define CR_LT_BIT            3
`define CR_GT_BIT            2
`define CR_EQ_BIT            1
`define CR_SO_BIT            0

// Interrupt bits
`define IRQ_DONE_BIT         0
`define IRQ_OVERFLOW_BIT     1
`define IRQ_ILLEGAL_BIT      2
`define IRQ_USED_MASK        32'h0000_0007

// Immediate field
`define IMM_MSB              15
`define IMM_USED_MASK        32'h0000_FFFF

// Reset values and bus responses
`define RESET_WORD           32'h0000_0000
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ---- design/ext_adder.v ----
// Add-to-zero, subtract-from-zero and negate unit, purely combinational.
// Assumes the caller registers the outputs and selects when to use them.
`include "int_arith_regs.vh"

module ext_adder (
   input  wire [31:0] operand,
   input  wire [2:0]  mode,
   input  wire        carry_in,
   output wire [31:0] sum,
   output wire        carry_out,
   output wire        overflow
);

   wire [31:0] addend;
   wire        cin;
   wire [32:0] total;

   assign addend = (mode == `OP_ADD_ZERO_EXT) ? operand : ~operand;
   assign cin    = (mode == `OP_NEGATE) ? 1'b1 : carry_in;
   assign total  = {1'b0, addend} + {32'h0000_0000, cin};

   assign sum       = total[31:0];
   assign carry_out = total[32];
   // Adding 0 or 1 can only overflow from the largest positive value
   assign overflow  = ~addend[31] & total[31];

endmodule // ext_adder

// ---- design/low_multiplier.v ----
// Signed 32 x 32 multiplier giving both product halves, purely combinational.
// Assumes the caller registers the outputs; one full-width array, no pipelining.
`include "int_arith_regs.vh"

module low_multiplier (
   input  wire [31:0] factor_a,
   input  wire [31:0] factor_b,
   output wire [31:0] product_low,
   output wire [31:0] product_high,
   output wire        overflow
);

   wire signed [63:0] product;

   assign product = $signed(factor_a) * $signed(factor_b);

   assign product_low  = product[31:0];
   assign product_high = product[63:32];

   // Result overflows when the high half is not the sign extension of the low half
   assign overflow = (product[63:32] != {32{product[31]}});

endmodule // low_multiplier

// ---- design/int_extended_add_multiply_low.v ----
// Extended add / subtract / negate and multiply-low slice behind an AXI4-Lite slave.
// Assumes a single-clock AXI4-Lite master; one write and one read in flight at most.
//
// Summary of operation
// - add-to-zero-extended writes source plus current carry bit.
// - record forms update condition field zero; other forms leave it alone.
// - overflow forms update overflow and summary overflow; others leave them.
// - multiply-low immediate: signed product with sign-extended immediate, low 32 bits.
// - multiply-low register: 64-bit product of two sources, low 32 bits written.
// - low half matches the signed high-word product so halves pair exactly.
`include "int_arith_regs.vh"

module int_extended_add_multiply_low (
   input  wire        clock,
   input  wire        rst_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         irq
);

   // Software visible state
   reg  [31:0] operand_a_reg;
   reg  [31:0] operand_b_reg;
   reg  [31:0] immediate_reg;
   reg  [31:0] command_reg;
   reg  [31:0] result_reg;
   reg  [31:0] product_high_reg;
   reg  [31:0] fixed_point_exception_reg;
   reg  [3:0]  condition_field_zero;
   reg  [31:0] irq_status_reg;
   reg  [31:0] irq_mask_reg;

   // Write channel holding
   reg  [7:0]  awaddr_reg;
   reg         aw_full_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         w_full_reg;

   wire        do_write;
   wire [3:0]  wr_idx;
   wire        wr_mapped;
   wire [31:0] byte_mask;
   wire        rd_take;
   wire [3:0]  rd_idx;
   wire        rd_mapped;

   assign do_write  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign wr_idx    = awaddr_reg[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
   assign wr_mapped = (awaddr_reg[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == 2'h0) &&
                      (wr_idx <= `IDX_IRQ_MASK);
   assign rd_take   = s_axi_arvalid & s_axi_arready;
   assign rd_idx    = s_axi_araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
   assign rd_mapped = (s_axi_araddr[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == 2'h0) &&
                      (rd_idx <= `IDX_IRQ_MASK);

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
         assign byte_mask[lane*8 +: 8] = {8{wstrb_reg[lane]}};
      end
   endgenerate

   // Merge a strobed write into the old value of a register
   function [31:0] merge;
      input [31:0] old_value;
      input [31:0] new_value;
      input [31:0] mask;
      begin
         merge = (old_value & ~mask) | (new_value & mask);
      end
   endfunction

   // Command launched by this write
   wire        launch;
   wire [31:0] cmd_word;
   wire [2:0]  op;
   wire        op_valid;
   wire        is_mul;
   wire        is_ext;
   wire        record_en;
   wire        ovf_en;
   wire [31:0] mul_factor_b;

   assign launch    = do_write && wr_mapped && (wr_idx == `IDX_COMMAND);
   assign cmd_word  = merge(command_reg, wdata_reg, byte_mask) & `CMD_USED_MASK;
   assign op        = cmd_word[`CMD_OP_MSB:`CMD_OP_LSB];
   assign op_valid  = (op <= `OP_MUL_LOW_REG);
   assign is_mul    = (op == `OP_MUL_LOW_IMM) || (op == `OP_MUL_LOW_REG);
   assign is_ext    = (op == `OP_ADD_ZERO_EXT) || (op == `OP_SUB_ZERO_EXT);
   // Immediate multiply has neither record nor overflow form
   assign record_en = cmd_word[`CMD_RECORD_BIT] && (op != `OP_MUL_LOW_IMM);
   assign ovf_en    = cmd_word[`CMD_OVF_EN_BIT] && (op != `OP_MUL_LOW_IMM);

   assign mul_factor_b = (op == `OP_MUL_LOW_IMM) ?
                         {{16{immediate_reg[`IMM_MSB]}}, immediate_reg[`IMM_MSB:0]} :
                         operand_b_reg;

   wire [31:0] add_sum;
   wire        add_carry;
   wire        add_ovf;
   wire [31:0] mul_low;
   wire [31:0] mul_high;
   wire        mul_ovf;

   ext_adder u_adder (
      .operand   (operand_a_reg),
      .mode      (op),
      .carry_in  (fixed_point_exception_reg[`XER_CARRY_BIT]),
      .sum       (add_sum),
      .carry_out (add_carry),
      .overflow  (add_ovf)
   );

   low_multiplier u_mult (
      .factor_a     (operand_a_reg),
      .factor_b     (mul_factor_b),
      .product_low  (mul_low),
      .product_high (mul_high),
      .overflow     (mul_ovf)
   );

   wire [31:0] op_result;
   wire        op_ovf;
   wire        new_carry;
   wire        new_ovf;
   wire        new_so;
   wire [3:0]  cr_value;

   assign op_result = is_mul ? mul_low : add_sum;
   assign op_ovf    = is_mul ? mul_ovf : add_ovf;
   // Only the extended adds produce a carry; the others keep it
   assign new_carry = is_ext ? add_carry : fixed_point_exception_reg[`XER_CARRY_BIT];
   assign new_ovf   = ovf_en ? op_ovf : fixed_point_exception_reg[`XER_OVERFLOW_BIT];
   assign new_so    = fixed_point_exception_reg[`XER_SUMMARY_OVF_BIT] | (ovf_en & op_ovf);

   assign cr_value[`CR_LT_BIT] = op_result[31];
   assign cr_value[`CR_GT_BIT] = ~op_result[31] & (|op_result);
   assign cr_value[`CR_EQ_BIT] = ~(|op_result);
   assign cr_value[`CR_SO_BIT] = new_so;

   // Interrupt events of this cycle
   reg  [31:0] irq_set;
   reg  [31:0] irq_clear;
   wire [31:0] irq_status_next;

   always @* begin
      irq_set = `RESET_WORD;
      irq_clear = `RESET_WORD;
      if (launch) begin
         irq_set[`IRQ_DONE_BIT]     = op_valid;
         irq_set[`IRQ_OVERFLOW_BIT] = op_valid & ovf_en & op_ovf;
         irq_set[`IRQ_ILLEGAL_BIT]  = ~op_valid;
      end
      if (do_write && wr_mapped && (wr_idx == `IDX_IRQ_STATUS)) begin
         irq_clear = wdata_reg & byte_mask & `IRQ_USED_MASK;
      end
   end

   // A new event beats a simultaneous clear
   assign irq_status_next = ((irq_status_reg & ~irq_clear) | irq_set) & `IRQ_USED_MASK;

   // Register file and execution
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         operand_a_reg             <= `RESET_WORD;
         operand_b_reg             <= `RESET_WORD;
         immediate_reg             <= `RESET_WORD;
         command_reg               <= `RESET_WORD;
         result_reg                <= `RESET_WORD;
         product_high_reg          <= `RESET_WORD;
         fixed_point_exception_reg <= `RESET_WORD;
         condition_field_zero      <= 4'h0;
         irq_status_reg            <= `RESET_WORD;
         irq_mask_reg              <= `RESET_WORD;
         irq                       <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         irq            <= |(irq_status_next & irq_mask_reg);
         if (do_write && wr_mapped) begin
            case (wr_idx)
               `IDX_OPERAND_A: begin
                  operand_a_reg <= merge(operand_a_reg, wdata_reg, byte_mask);
               end
               `IDX_OPERAND_B: begin
                  operand_b_reg <= merge(operand_b_reg, wdata_reg, byte_mask);
               end
               `IDX_IMMEDIATE: begin
                  immediate_reg <= merge(immediate_reg, wdata_reg, byte_mask) & `IMM_USED_MASK;
               end
               `IDX_COMMAND: begin
                  command_reg <= cmd_word;
                  // An unknown operation changes no result or flag
                  if (op_valid) begin
                     result_reg <= op_result;
                     product_high_reg <= is_mul ? mul_high : product_high_reg;
                     fixed_point_exception_reg <= ({31'h0, new_carry} << `XER_CARRY_BIT) |
                                                  ({31'h0, new_ovf} << `XER_OVERFLOW_BIT) |
                                                  ({31'h0, new_so} << `XER_SUMMARY_OVF_BIT);
                     if (record_en) begin
                        condition_field_zero <= cr_value;
                     end
                  end
               end
               `IDX_FIXED_POINT_EXC: begin
                  fixed_point_exception_reg <=
                     merge(fixed_point_exception_reg, wdata_reg, byte_mask) & `XER_USED_MASK;
               end
               `IDX_IRQ_MASK: begin
                  irq_mask_reg <= merge(irq_mask_reg, wdata_reg, byte_mask) & `IRQ_USED_MASK;
               end
               default: begin
                  // Read-only registers and status ignore plain writes
               end
            endcase
         end
      end
   end

   // AXI4-Lite write channels: address and data in either order
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         awaddr_reg    <= 8'h00;
         aw_full_reg   <= 1'b0;
         wdata_reg     <= `RESET_WORD;
         wstrb_reg     <= 4'h0;
         w_full_reg    <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg    <= s_axi_awaddr;
            aw_full_reg   <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            w_full_reg   <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         // Channels reopen only after the response, keeping one write in flight
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read data mux
   reg [31:0] rd_value;

   always @* begin
      rd_value = `RESET_WORD;
      case (rd_idx)
         `IDX_OPERAND_A:       rd_value = operand_a_reg;
         `IDX_OPERAND_B:       rd_value = operand_b_reg;
         `IDX_IMMEDIATE:       rd_value = immediate_reg;
         `IDX_COMMAND:         rd_value = command_reg;
         `IDX_RESULT:          rd_value = result_reg;
         `IDX_PRODUCT_HIGH:    rd_value = product_high_reg;
         `IDX_FIXED_POINT_EXC: rd_value = fixed_point_exception_reg;
         `IDX_CONDITION_ZERO:  rd_value = {28'h0000000, condition_field_zero};
         `IDX_IRQ_STATUS:      rd_value = irq_status_reg;
         `IDX_IRQ_MASK:        rd_value = irq_mask_reg;
         default:              rd_value = `RESET_WORD;
      endcase
      if (!rd_mapped) begin
         rd_value = `RESET_WORD;
      end
   end

   // AXI4-Lite read channels
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `RESET_WORD;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // int_extended_add_multiply_low

// ---- tb/axil_master.sv ----
// AXI4-Lite master model standing in for the core's decode side.
// Assumes one clock; the bench calls one task at a time, each after a clock edge.
module axil_master (
   input  wire         clock,
   output logic [7:0]  s_axi_awaddr,
   output logic [2:0]  s_axi_awprot,
   output logic        s_axi_awvalid,
   input  wire         s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0]  s_axi_wstrb,
   output logic        s_axi_wvalid,
   input  wire         s_axi_wready,
   input  wire  [1:0]  s_axi_bresp,
   input  wire         s_axi_bvalid,
   output logic        s_axi_bready,
   output logic [7:0]  s_axi_araddr,
   output logic [2:0]  s_axi_arprot,
   output logic        s_axi_arvalid,
   input  wire         s_axi_arready,
   input  wire  [31:0] s_axi_rdata,
   input  wire  [1:0]  s_axi_rresp,
   input  wire         s_axi_rvalid,
   output logic        s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cycles by which write data trails the address, to exercise the slow side
   int lag = 0;
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   task automatic write_word(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] resp, output logic hung);
      hung = 1'b1;
      @(posedge clock);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= (lag == 0);
      s_axi_bready  <= 1'b1;
      for (int n = 0; n < 64 && hung; n++) begin
         @(posedge clock);
         if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (n + 1 == lag) s_axi_wvalid <= 1'b1;
         if (s_axi_bvalid === 1'b1) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            hung = 1'b0;
         end
      end
   endtask
   task automatic read_word(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp, output logic hung);
      hung = 1'b1;
      @(posedge clock);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int n = 0; n < 64 && hung; n++) begin
         @(posedge clock);
         if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            hung = 1'b0;
         end
      end
   endtask
endmodule // axil_master

// ---- tb/int_extended_add_multiply_low_checker.sv ----
// Port-level assertions for the extended add / multiply-low slice.
// Assumes full-word writes with address and data offered together.
module arith_checker (
   input wire        clock,
   input wire        rst_n,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   // Shadow of operand and carry; later writes with data trailing are not tracked
   logic [31:0] a_sh, exp_sh;
   logic        carry_sh, pend;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {a_sh, exp_sh, carry_sh, pend} <= '0;
      end else if (wr_take) begin
         if (s_axi_awaddr == 8'h00) a_sh <= s_axi_wdata;
         if (s_axi_awaddr == 8'h18) carry_sh <= s_axi_wdata[0];
         if (s_axi_awaddr == 8'h0C) begin
            pend <= (s_axi_wdata[2:0] == 3'h0) || (s_axi_wdata[2:0] == 3'h2);
            exp_sh <= s_axi_wdata[1] ? ~a_sh + 32'h1 : a_sh + {31'h0, carry_sh};
         end
      end
   end
   AST_ADD_NEG_RESULT: assert property (ar_take && s_axi_araddr == 8'h10 && pend
      |-> ##2 s_axi_rdata == exp_sh) else $error("add or negate result wrong");
   AST_B_LATENCY: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_R_LATENCY: assert property (ar_take |-> ##1 s_axi_rvalid)
      else $error("read response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_BUSY_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   AST_UNMAPPED_READ: assert property (ar_take && (s_axi_araddr[7:6] != 2'h0
      || s_axi_araddr[5:2] > 4'h9) |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_IRQ_MASKED: assert property (wr_take && s_axi_awaddr == 8'h24 && s_axi_wdata == 32'h0
      |-> ##3 !irq) else $error("interrupt high with mask clear");
   AST_READY_AFTER_RESET: assert property ($rose(rst_n) |-> s_axi_awready && s_axi_arready)
      else $error("not ready after reset");
   COV_COMMAND: cover property (wr_take && s_axi_awaddr == 8'h0C);
   COV_IRQ: cover property ($rose(irq));
   COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // arith_checker
bind int_extended_add_multiply_low arith_checker chk_u (.*);

// ---- tb/int_extended_add_multiply_low_tb_top.sv ----
// Self-checking bench: operation table, then reset, refusal and interrupt cases.
// Assumes the design answers on AXI4-Lite within the master model's bound.
module int_extended_add_multiply_low_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst_n, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          num_errors = 0;
   int          compares = 0;
   typedef struct packed {logic [4:0] cmd; logic [31:0] a, b, imm; logic [2:0] exc;} row_t;
   row_t rows [9] = '{
      '{5'h18, 32'h7FFFFFFF, 32'h0, 32'h0, 3'h1}, '{5'h08, 32'hFFFFFFFF, 32'h0, 32'h0, 3'h1},
      '{5'h11, 32'h80000000, 32'h0, 32'h0, 3'h1}, '{5'h01, 32'h00000005, 32'h0, 32'h0, 3'h6},
      '{5'h1A, 32'h80000000, 32'h0, 32'h0, 3'h0}, '{5'h0A, 32'h00000001, 32'h0, 32'h0, 3'h0},
      '{5'h1B, 32'h00012345, 32'h0, 32'hABCDFFFE, 3'h1},
      '{5'h1C, 32'h80000000, 32'h2, 32'h0, 3'h0}, '{5'h0C, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 3'h0}};
   int_extended_add_multiply_low dut_u (.*);
   axil_master master_u (.*);
   initial clock = 1'b0;
   always #5 clock = ~clock;
   task automatic tally_and_finish;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [1:0] resp_of(input logic [7:0] a);
      return (a[7:6] != 2'h0 || a[5:2] > 4'h9) ? 2'h2 : 2'h0;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      logic       h;
      master_u.write_word(a, d, r, h);
      if (h) num_errors++;
      if (h) tally_and_finish();
      check("bresp", {30'h0, r}, {30'h0, resp_of(a)});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      logic       h;
      master_u.read_word(a, d, r, h);
      if (h) num_errors++;
      if (h) tally_and_finish();
      check("rresp", {30'h0, r}, {30'h0, resp_of(a)});
   endtask
   // Result, high half, flags and condition field as the operation defines them
   function automatic logic [70:0] model(input row_t r, input logic [3:0] cond_old);
      logic [63:0] p;
      logic [31:0] res;
      logic [2:0]  x;
      logic [3:0]  cond;
      logic        ovf;
      x = r.exc;
      ovf = 1'b0;
      p = 64'h0;
      case (r.cmd[2:0])
         3'h0: {x[0], res} = {1'b0, r.a} + {32'h0, r.exc[0]};
         3'h1: {x[0], res} = {1'b0, ~r.a} + {32'h0, r.exc[0]};
         3'h2: res = ~r.a + 32'h1;
         3'h3: p = $signed(r.a) * $signed({{16{r.imm[15]}}, r.imm[15:0]});
         default: p = $signed(r.a) * $signed(r.b);
      endcase
      if (r.cmd[2:0] > 3'h2) res = p[31:0];
      if (r.cmd[2:0] == 3'h0) ovf = (r.a == 32'h7FFFFFFF) && r.exc[0];
      if (r.cmd[2:0] == 3'h1) ovf = (r.a == 32'h80000000) && r.exc[0];
      if (r.cmd[2:0] == 3'h2) ovf = (r.a == 32'h80000000);
      if (r.cmd[2:0] == 3'h4) ovf = (p[63:32] != {32{p[31]}});
      if (r.cmd[4] && r.cmd[2:0] != 3'h3) x[2:1] = {x[2] | ovf, ovf};
      cond = cond_old;
      if (r.cmd[3] && r.cmd[2:0] != 3'h3)
         cond = {res[31], !res[31] && res != 32'h0, res == 32'h0, x[2]};
      return {res, p[63:32], x, cond};
   endfunction
   initial begin
      logic [31:0] d;
      logic [70:0] e;
      logic [3:0]  cond_exp;
      rst_n = 1'b0;
      cond_exp = 4'h0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rd(8'(i * 4), d);
         check("reset value", d, 32'h0);
      end
      for (int i = 0; i < 9; i++) begin
         e = model(rows[i], cond_exp);
         cond_exp = e[3:0];
         wr(8'h18, {29'h0, rows[i].exc});
         wr(8'h00, rows[i].a);
         wr(8'h04, rows[i].b);
         wr(8'h08, rows[i].imm);
         wr(8'h0C, {27'h0, rows[i].cmd});
         rd(8'h10, d);
         check("result", d, e[70:39]);
         rd(8'h18, d);
         check("fixed_point_exception_reg", d, {29'h0, e[6:4]});
         rd(8'h1C, d);
         check("condition_field_zero", d, {28'h0, e[3:0]});
         rd(8'h14, d);
         if (rows[i].cmd[2:0] > 3'h2) check("product_high", d, e[38:7]);
      end
      // Read-only result ignores writes; unmapped places refuse and read zero
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, d);
      check("result kept", d, 32'h1);
      wr(8'h40, 32'h1);
      rd(8'h28, d);
      check("unmapped data", d, 32'h0);
      // Data trailing the address by two cycles
      master_u.lag = 2;
      wr(8'h04, 32'h5A5A5A5A);
      master_u.lag = 0;
      rd(8'h04, d);
      check("operand b", d, 32'h5A5A5A5A);
      wr(8'h24, 32'h7);
      repeat (2) @(posedge clock);
      check("irq raised", {31'h0, irq}, 32'h1);
      wr(8'h20, 32'h7);
      rd(8'h20, d);
      check("status cleared", d, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
      wr(8'h0C, 32'h5);
      rd(8'h20, d);
      check("illegal status", d, 32'h4);
      wr(8'h24, 32'h0);
      repeat (3) @(posedge clock);
      check("irq masked", {31'h0, irq}, 32'h0);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(8'h20, d);
      check("status after reset", d, 32'h0);
      check("irq after reset", {31'h0, irq}, 32'h0);
      tally_and_finish();
   end
endmodule // int_extended_add_multiply_low_tb_top
